// [tlem_pkg.sv]
// Constants, types and helper functions shared by the link error monitor
// What this block does
// - Out of service, compare each packet bitwise with the test packet.
// - After correction, report a running errored bit count, not a ratio.
// - Before correction, rate is errored bits over all bits received.
// - Accumulate rate figures only while the link is available.
// - In service, packet errors are bits differing before and after decoding.
// - Flag the in-service rate unreliable once above one in a thousand.
// - Any accepted uncorrectable packet restarts the in-service rate from zero.
// - Log three event kinds: sync loss, signal loss and errored packets.
// - For each loss, log when it began and how long it lasted.
// - Time base defaults to one second; the interval is configurable.
// - Errored blocks: log count per interval, identifier and packet total.
// - Optionally log extra items such as decoder overload.
// - The log holds at least the 1000 most recent events.
// - An external reader can fetch every logged entry in structured form.
// - A decoder overload marks the packet as uncorrectable.
// - Unavailability starts on N straight bad intervals or M in window T.
package tlem_pkg;

  localparam int PKT_BYTES = 188;
  localparam logic [7:0] TEST_HDR0 = 8'h47;
  localparam logic [7:0] TEST_HDR1 = 8'h1f;
  localparam logic [7:0] TEST_HDR2 = 8'hff;
  localparam logic [7:0] TEST_HDR3 = 8'h10;
  localparam logic [7:0] TEST_FILL = 8'h00;
  localparam int LOG_DEPTH = 1024;
  localparam int LOG_AW    = 10;
  localparam int BER_W     = 48;
  localparam int TIME_W    = 32;
  localparam int CNT_W     = 16;
  localparam logic [9:0]  BER_INV_LIMIT = 10'h3e8;
  localparam logic [6:0]  PCT_SCALE     = 7'h64;
  localparam logic [7:0]  RES_DEFAULT   = 8'h01;

  typedef enum logic [1:0] {
    EV_SYNC   = 2'h0,
    EV_SIGNAL = 2'h1,
    EV_BLOCK  = 2'h3
  } tlem_event_type;

  typedef enum logic {
    LOSS_NONE   = 1'b0,
    LOSS_ACTIVE = 1'b1
  } tlem_loss_type;

  typedef struct packed {
    tlem_event_type    kind;
    logic              overload;
    logic [TIME_W-1:0] start;
    logic [TIME_W-1:0] arg;
    logic [12:0]       pid;
    logic [CNT_W-1:0]  total;
  } tlem_entry_type;

  function automatic logic [3:0] popcount8(input logic [7:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++) begin
      n = n + {3'h0, v[i]};
    end
    return n;
  endfunction : popcount8

  function automatic logic [4:0] popcount16(input logic [15:0] v);
    logic [4:0] n;
    n = 5'h0;
    for (int i = 0; i < 16; i++) begin
      n = n + {4'h0, v[i]};
    end
    return n;
  endfunction : popcount16

  function automatic logic [7:0] test_byte(input logic [7:0] idx);
    logic [7:0] b;
    b = TEST_FILL;
    unique case (idx)
      8'h00: b = TEST_HDR0;
      8'h01: b = TEST_HDR1;
      8'h02: b = TEST_HDR2;
      8'h03: b = TEST_HDR3;
      default: b = TEST_FILL;
    endcase
    return b;
  endfunction : test_byte

endpackage : tlem_pkg

// [tlem_log_if.sv]
// Write and read path between the monitor core and its event log
`timescale 1ns/1ps
interface tlem_log_if #(parameter int AW = 10);
  import tlem_pkg::*;
  logic           wr_valid;
  tlem_entry_type wr_entry;
  logic [AW-1:0]  rd_idx;
  tlem_entry_type rd_entry;
  logic [AW:0]    fill;

  modport src   (output wr_valid, wr_entry, rd_idx, input rd_entry, fill);
  modport store (input wr_valid, wr_entry, rd_idx, output rd_entry, fill);
endinterface : tlem_log_if

// [tlem_ber_acc.sv]
// Bit error accumulator: counts differing bits and compared bits
`timescale 1ns/1ps
module tlem_ber_acc
  import tlem_pkg::*;
(
  input  wire logic             sys_clk,   // System clock
  input  wire logic             rst_b,     // Sync reset, active low
  input  wire logic             clr,       // Restart the measurement
  input  wire logic             en,        // Compare this byte
  input  wire logic [7:0]       a_byte,    // Received byte
  input  wire logic [7:0]       b_byte,    // Reference byte
  output logic      [BER_W-1:0] err_bits,  // Errored bits so far
  output logic      [BER_W-1:0] tot_bits   // Compared bits so far
);

  typedef struct packed {
    logic [BER_W-1:0] err;
    logic [BER_W-1:0] tot;
  } tlem_acc_state_type;

  tlem_acc_state_type s_q, s_d;

  always_comb begin
    s_d = s_q;
    if (clr) begin
      s_d = '0;
    end else if (en) begin
      s_d.err = s_q.err + BER_W'(popcount8(a_byte ^ b_byte));
      s_d.tot = s_q.tot + BER_W'(8);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign err_bits = s_q.err;
  assign tot_bits = s_q.tot;

endmodule : tlem_ber_acc

// [tlem_event_log.sv]
// Circular event log; read index 0 is the newest entry
`timescale 1ns/1ps
module tlem_event_log
  import tlem_pkg::*;
#(
  parameter int DEPTH = LOG_DEPTH,
  parameter int AW    = LOG_AW
)(
  input wire logic sys_clk,  // System clock
  input wire logic rst_b,    // Sync reset, active low
  tlem_log_if.store lg       // Write and read port
);

  typedef struct packed {
    logic [AW-1:0]  ptr;
    logic [AW:0]    fill;
    tlem_entry_type rd;
  } tlem_log_state_type;

  tlem_log_state_type s_q, s_d;
  tlem_entry_type     mem [DEPTH];

  always_comb begin
    s_d = s_q;
    s_d.rd = mem[AW'(s_q.ptr - AW'(1) - lg.rd_idx)];
    if (lg.wr_valid) begin
      s_d.ptr = (s_q.ptr == AW'(DEPTH - 1)) ? '0 : s_q.ptr + AW'(1);
      if (s_q.fill != (AW + 1)'(DEPTH)) begin
        s_d.fill = s_q.fill + (AW + 1)'(1);
      end
    end
  end

  // Storage has no reset; fill tells the reader how much is valid
  always_ff @(posedge sys_clk) begin
    if (lg.wr_valid) begin
      mem[s_q.ptr] <= lg.wr_entry;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign lg.rd_entry = s_q.rd;
  assign lg.fill     = s_q.fill;

endmodule : tlem_event_log

// [tlem_monitor.sv]
// Link error monitor: rate, error count, availability and event logging
`timescale 1ns/1ps
module tlem_monitor
  import tlem_pkg::*;
#(
  parameter int RUN_N = 10,   // Straight bad or good intervals
  parameter int WIN_T = 16,   // Rolling window length, at most 16
  parameter int WIN_M = 4     // Bad intervals in window to go down
)(
  input  wire logic              sys_clk,        // 10 MHz clock
  input  wire logic              rst_b,          // Sync reset, active low
  input  wire logic              byte_valid,     // Byte pair valid
  input  wire logic              byte_sop,       // First byte of packet
  input  wire logic [7:0]        pre_byte,       // Byte before correction
  input  wire logic [7:0]        post_byte,      // Byte after correction
  input  wire logic              rs_overload,    // Decoder gave up, last byte
  input  wire logic              in_sync,        // Packet sync held
  input  wire logic              signal_ok,      // Carrier present
  input  wire logic              sec_tick,       // One-second pulse
  input  wire logic              oos_mode,       // Test packet mode
  input  wire logic              meas_clear,     // Restart measurements
  input  wire logic [7:0]        res_secs,       // Seconds per interval
  input  wire logic [6:0]        sus_pct,        // Bad-interval percent
  input  wire logic [LOG_AW-1:0] log_rd_idx,     // Entry age, 0 newest
  output logic      [BER_W-1:0]  ber_err_bits,   // Rate numerator
  output logic      [BER_W-1:0]  ber_total_bits, // Rate denominator
  output logic                   ber_unreliable, // Rate above limit
  output logic      [BER_W-1:0]  post_err_count, // Errors after correction
  output logic                   link_unavail,   // Link unavailable
  output logic                   sync_lost,      // Sync loss in progress
  output logic                   signal_lost,    // Signal loss in progress
  output logic      [TIME_W-1:0] time_now,       // Seconds since reset
  output logic      [LOG_AW:0]   log_fill,       // Valid log entries
  output tlem_entry_type         log_entry       // Entry at log_rd_idx
);

  typedef struct packed {
    logic [7:0]        idx;
    logic [12:0]       pid;
    logic              tei;
    logic [TIME_W-1:0] now;
    logic [7:0]        res_cnt;
    logic [CNT_W-1:0]  int_pkts;
    logic [CNT_W-1:0]  int_unc;
    logic              int_loss;
    logic [7:0]        bad_run;
    logic [7:0]        good_run;
    logic [15:0]       win;
    logic              unavail;
    logic              unrel;
    logic              oos_last;
    tlem_loss_type     sync_st;
    logic [TIME_W-1:0] sync_t0;
    tlem_loss_type     sig_st;
    logic [TIME_W-1:0] sig_t0;
    logic              eb_have;
    logic [12:0]       eb_pid;
    logic [CNT_W-1:0]  eb_cnt;
    logic [CNT_W-1:0]  eb_tot;
    logic              eb_ovl;
    logic              p_sync;
    logic [TIME_W-1:0] p_sync_t0;
    logic [TIME_W-1:0] p_sync_dur;
    logic              p_sig;
    logic [TIME_W-1:0] p_sig_t0;
    logic [TIME_W-1:0] p_sig_dur;
    logic              p_eb;
    tlem_entry_type    p_eb_e;
    logic              wr_valid;
    tlem_entry_type    wr_entry;
  } tlem_mon_state_type;

  tlem_mon_state_type s_q, s_d;
  tlem_log_if #(.AW(LOG_AW)) lg ();

  logic [7:0]       cur_idx;
  logic [7:0]       exp_byte;
  logic             pkt_last;
  logic             pkt_unc;
  logic             acc_en;
  logic             pre_clr;
  logic [7:0]       ref_byte;
  logic [BER_W-1:0] pre_err;
  logic [BER_W-1:0] pre_tot;
  logic             int_tick;
  logic [7:0]       res_eff;
  logic [23:0]      unc_scaled;
  logic [23:0]      lim_scaled;
  logic             int_bad;
  logic [15:0]      win_next;

  always_comb begin
    cur_idx  = byte_sop ? 8'h00 : s_q.idx;
    exp_byte = test_byte(cur_idx);
    pkt_last = byte_valid && (cur_idx == 8'(PKT_BYTES - 1));
    // Overload or the relayed error indicator both mean uncorrectable
    pkt_unc  = pkt_last && (rs_overload || s_q.tei);
    // Out-of-sync bytes never reach the totals
    acc_en   = byte_valid && in_sync && signal_ok
               && !s_q.unavail;
    ref_byte = oos_mode ? exp_byte : post_byte;
    // A refused packet may not restart the rate either
    pre_clr  = meas_clear || (oos_mode != s_q.oos_last)
               || (!oos_mode && pkt_unc && acc_en);
    res_eff  = (res_secs == 8'h00) ? RES_DEFAULT : res_secs;
    int_tick = sec_tick && (s_q.res_cnt + 8'h01 >= res_eff);
    unc_scaled = 24'(s_q.int_unc) * 24'(PCT_SCALE);
    lim_scaled = 24'(s_q.int_pkts) * 24'(sus_pct);
    int_bad  = (unc_scaled > lim_scaled) || s_q.int_loss;
    win_next = {s_q.win[14:0], int_bad}
               & 16'(({16'h0, 1'b1} << WIN_T) - 17'h1);
  end

  always_comb begin
    s_d = s_q;
    s_d.oos_last = oos_mode;
    s_d.wr_valid = 1'b0;

    if (byte_valid) begin
      s_d.idx = pkt_last ? 8'h00 : cur_idx + 8'h01;
      if (cur_idx == 8'h01) begin
        s_d.tei      = post_byte[7];
        s_d.pid[12:8] = post_byte[4:0];
      end
      if (cur_idx == 8'h02) begin
        s_d.pid[7:0] = post_byte;
      end
    end

    // Time base and interval counter
    if (sec_tick) begin
      s_d.now     = s_q.now + TIME_W'(1);
      s_d.res_cnt = int_tick ? 8'h00 : s_q.res_cnt + 8'h01;
    end

    // Rate reliability check: err * 1000 > total
    s_d.unrel = (BER_W'(pre_err * BER_INV_LIMIT) > pre_tot)
                && !oos_mode;
    if (pre_clr) begin
      s_d.unrel = 1'b0;
    end

    // Loss tracking, timestamps in seconds
    if (s_q.sync_st == LOSS_NONE && !in_sync) begin
      s_d.sync_st = LOSS_ACTIVE;
      s_d.sync_t0 = s_q.now;
    end else if (s_q.sync_st == LOSS_ACTIVE && in_sync) begin
      s_d.sync_st    = LOSS_NONE;
      s_d.p_sync     = 1'b1;
      s_d.p_sync_t0  = s_q.sync_t0;
      s_d.p_sync_dur = s_q.now - s_q.sync_t0;
    end
    if (s_q.sig_st == LOSS_NONE && !signal_ok) begin
      s_d.sig_st = LOSS_ACTIVE;
      s_d.sig_t0 = s_q.now;
    end else if (s_q.sig_st == LOSS_ACTIVE && signal_ok) begin
      s_d.sig_st    = LOSS_NONE;
      s_d.p_sig     = 1'b1;
      s_d.p_sig_t0  = s_q.sig_t0;
      s_d.p_sig_dur = s_q.now - s_q.sig_t0;
    end

    // Per-interval packet statistics
    if (!in_sync || !signal_ok) begin
      s_d.int_loss = 1'b1;
    end
    if (pkt_last && in_sync) begin
      s_d.int_pkts = s_q.int_pkts + CNT_W'(1);
      if (pkt_unc) begin
        s_d.int_unc = s_q.int_unc + CNT_W'(1);
      end
      // One identifier is followed per interval: the first errored one
      if (!s_q.eb_have && pkt_unc) begin
        s_d.eb_have = 1'b1;
        s_d.eb_pid  = s_q.pid;
        s_d.eb_cnt  = CNT_W'(1);
        s_d.eb_tot  = CNT_W'(1);
        s_d.eb_ovl  = rs_overload;
      end else if (s_q.eb_have && s_q.pid == s_q.eb_pid) begin
        s_d.eb_tot = s_q.eb_tot + CNT_W'(1);
        if (pkt_unc) begin
          s_d.eb_cnt = s_q.eb_cnt + CNT_W'(1);
          s_d.eb_ovl = s_q.eb_ovl | rs_overload;
        end
      end
    end

    // Interval close: availability and errored block record
    if (int_tick) begin
      // A packet ending on the tick opens the next interval
      s_d.int_pkts = CNT_W'(pkt_last && in_sync);
      s_d.int_unc  = CNT_W'(pkt_last && in_sync && pkt_unc);
      s_d.int_loss = !in_sync || !signal_ok;
      s_d.win      = win_next;
      s_d.bad_run  = int_bad ? s_q.bad_run + 8'h01 : 8'h00;
      s_d.good_run = int_bad ? 8'h00 : s_q.good_run + 8'h01;
      if (s_q.bad_run == 8'hff) begin
        s_d.bad_run = s_q.bad_run;
      end
      if (s_q.good_run == 8'hff) begin
        s_d.good_run = s_q.good_run;
      end
      if (!s_q.unavail) begin
        if (s_d.bad_run >= 8'(RUN_N)
            || popcount16(win_next) >= 5'(WIN_M)) begin
          s_d.unavail = 1'b1;
        end
      end else if (s_d.good_run >= 8'(RUN_N)
                   || win_next == 16'h0000) begin
        s_d.unavail = 1'b0;
      end
      s_d.eb_have = pkt_last && in_sync && pkt_unc;
      s_d.eb_pid  = s_q.pid;
      s_d.eb_cnt  = CNT_W'(1);
      s_d.eb_tot  = CNT_W'(1);
      s_d.eb_ovl  = rs_overload;
      if (s_q.eb_have) begin
        s_d.p_eb            = 1'b1;
        s_d.p_eb_e.kind     = EV_BLOCK;
        s_d.p_eb_e.overload = s_q.eb_ovl;
        s_d.p_eb_e.start    = s_q.now;
        s_d.p_eb_e.arg      = TIME_W'(s_q.eb_cnt);
        s_d.p_eb_e.pid      = s_q.eb_pid;
        s_d.p_eb_e.total    = s_q.eb_tot;
      end
    end

    // One log write per cycle; a new event in the same cycle re-arms
    if (s_q.p_sync) begin
      s_d.wr_valid = 1'b1;
      s_d.wr_entry = '{EV_SYNC, 1'b0, s_q.p_sync_t0, s_q.p_sync_dur,
                       13'h0000, '0};
      if (!(s_q.sync_st == LOSS_ACTIVE && in_sync)) begin
        s_d.p_sync = 1'b0;
      end
    end else if (s_q.p_sig) begin
      s_d.wr_valid = 1'b1;
      s_d.wr_entry = '{EV_SIGNAL, 1'b0, s_q.p_sig_t0, s_q.p_sig_dur,
                       13'h0000, '0};
      if (!(s_q.sig_st == LOSS_ACTIVE && signal_ok)) begin
        s_d.p_sig = 1'b0;
      end
    end else if (s_q.p_eb) begin
      s_d.wr_valid = 1'b1;
      s_d.wr_entry = s_q.p_eb_e;
      if (!(int_tick && s_q.eb_have)) begin
        s_d.p_eb = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Before correction: against the test packet or the corrected packet
  tlem_ber_acc u_pre (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .clr      (pre_clr),
    .en       (acc_en),
    .a_byte   (pre_byte),
    .b_byte   (ref_byte),
    .err_bits (pre_err),
    .tot_bits (pre_tot)
  );

  // After correction, test packet only; reported as a plain count
  tlem_ber_acc u_post (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .clr      (meas_clear || !oos_mode),
    .en       (acc_en && oos_mode),
    .a_byte   (post_byte),
    .b_byte   (exp_byte),
    .err_bits (post_err_count),
    .tot_bits ()
  );

  tlem_event_log #(.DEPTH(LOG_DEPTH), .AW(LOG_AW)) u_log (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .lg      (lg.store)
  );

  assign lg.wr_valid = s_q.wr_valid;
  assign lg.wr_entry = s_q.wr_entry;
  assign lg.rd_idx   = log_rd_idx;

  assign ber_err_bits   = pre_err;
  assign ber_total_bits = pre_tot;
  assign ber_unreliable = s_q.unrel;
  assign link_unavail   = s_q.unavail;
  assign sync_lost      = (s_q.sync_st == LOSS_ACTIVE);
  assign signal_lost    = (s_q.sig_st == LOSS_ACTIVE);
  assign time_now       = s_q.now;
  assign log_fill       = lg.fill;
  assign log_entry      = lg.rd_entry;

endmodule : tlem_monitor

// [tlem_mon_assertions.sv]
// Port checks for the link error monitor
`timescale 1ns/1ps
module tlem_mon_assertions
  import tlem_pkg::*;
(
  input wire logic              sys_clk,        // Clock
  input wire logic              rst_b,          // Reset
  input wire logic              byte_valid,     // Byte valid
  input wire logic [7:0]        pre_byte,       // Raw byte
  input wire logic [7:0]        post_byte,      // Fixed byte
  input wire logic              rs_overload,    // Overload
  input wire logic              in_sync,        // Sync held
  input wire logic              signal_ok,      // Carrier
  input wire logic              sec_tick,       // Second
  input wire logic              oos_mode,       // Test mode
  input wire logic              meas_clear,     // Clear
  input wire logic [BER_W-1:0]  ber_err_bits,   // Errors
  input wire logic [BER_W-1:0]  ber_total_bits, // Bits
  input wire logic              ber_unreliable, // Over limit
  input wire logic [BER_W-1:0]  post_err_count, // Count
  input wire logic              link_unavail,   // Down
  input wire logic              sync_lost,      // Sync loss
  input wire logic              signal_lost,    // Signal loss
  input wire logic [TIME_W-1:0] time_now,       // Seconds
  input wire logic [LOG_AW:0]   log_fill        // Entries
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  logic       take;
  logic       over;
  logic [7:0] diff;
  assign take = byte_valid && in_sync && signal_ok && !link_unavail;
  assign diff = pre_byte ^ post_byte;
  // Wide product so the limit test cannot wrap
  assign over = ({10'h0, ber_err_bits} * 58'd1000) > {10'h0, ber_total_bits};

  err_step_a: assert property (
    take && !meas_clear && !rs_overload && !oos_mode && $stable(oos_mode)
    |=> ber_err_bits == 48'h0 ||
        ber_err_bits == $past(ber_err_bits) + 48'($countones($past(diff))))
    else $error("errored bits did not add the differing bits");
  bit_step_a: assert property (
    take && !meas_clear && !rs_overload && $stable(oos_mode) |=>
    ber_total_bits == $past(ber_total_bits) + 48'h8 ||
    ber_total_bits <= 48'h8)
    else $error("compared bits did not step by eight");
  refused_hold_a: assert property (
    (!byte_valid || !in_sync || !signal_ok || link_unavail) && !meas_clear
    && !rs_overload && $stable(oos_mode) |=> $stable(ber_total_bits))
    else $error("refused byte changed the bit total");
  clear_all_a: assert property (
    meas_clear |=> ber_err_bits == 48'h0 && ber_total_bits == 48'h0
    && post_err_count == 48'h0)
    else $error("clear left a count behind");
  overload_restart_a: assert property (
    take && rs_overload && !oos_mode |=>
    ber_err_bits == 48'h0 && ber_total_bits == 48'h0)
    else $error("overload did not restart the rate");
  rate_limit_a: assert property (
    // A restart zeroes the total and the flag together
    !oos_mode ##1 !oos_mode |=>
    ber_unreliable == ($past(over) && ber_total_bits != 48'h0))
    else $error("unreliable flag disagrees with the rate");
  post_zero_a: assert property (
    !oos_mode [*2] |-> post_err_count == 48'h0)
    else $error("post count nonzero in service");
  sync_flag_a: assert property (
    sync_lost == !$past(in_sync))
    else $error("sync loss flag late or wrong");
  signal_flag_a: assert property (
    signal_lost == !$past(signal_ok))
    else $error("signal loss flag late or wrong");
  log_fill_a: assert property (
    log_fill >= $past(log_fill) && log_fill <= 11'h400)
    else $error("log fill fell or overran");
  time_base_a: assert property (
    time_now == $past(time_now) + {31'h0, $past(sec_tick)})
    else $error("time base did not follow the tick");
endmodule : tlem_mon_assertions

bind tlem_monitor tlem_mon_assertions chk_i (
  .sys_clk, .rst_b, .byte_valid, .pre_byte, .post_byte, .rs_overload,
  .in_sync, .signal_ok, .sec_tick, .oos_mode, .meas_clear, .ber_err_bits,
  .ber_total_bits, .ber_unreliable, .post_err_count, .link_unavail,
  .sync_lost, .signal_lost, .time_now, .log_fill
);

// [tlem_src_model.sv]
// Far-side model: decoder chain handing over packet byte pairs
`timescale 1ns/1ps
module tlem_src_model (
  input  wire logic       sys_clk,    // Clock
  input  wire logic       go,         // Start one packet
  input  wire logic       oos,        // Send the fixed test packet
  input  wire logic [7:0] pm,         // Bits wrong after correction
  input  wire logic [7:0] qm,         // Bits the decoder corrected
  input  wire logic       ovl,        // Decoder gives up
  input  wire logic       tei,        // Relay marked it uncorrectable
  output logic            busy,       // Packet in flight
  output logic            byte_valid, // Byte pair valid
  output logic            byte_sop,   // First byte
  output logic      [7:0] pre_byte,   // Before correction
  output logic      [7:0] post_byte,  // After correction
  output logic            rs_overload // Overload on last byte
);
  function automatic logic [7:0] fixed_byte(input int i);
    case (i)
      0: return 8'h47;
      1: return 8'h1f;
      2: return 8'hff;
      3: return 8'h10;
      default: return 8'h00;
    endcase
  endfunction : fixed_byte

  initial begin
    logic [7:0] b;
    logic [7:0] e;
    busy = 1'b0;
    byte_valid = 1'b0;
    byte_sop = 1'b0;
    pre_byte = 8'h00;
    post_byte = 8'h00;
    rs_overload = 1'b0;
    forever begin
      @(posedge sys_clk);
      if (go) begin
        busy <= 1'b1;
        for (int i = 0; i < 188; i++) begin
          b = oos ? fixed_byte(i) : 8'(i * 7 + 3);
          // The mark reaches both copies: the relay rebuilt parity for it
          if (i == 1 && !oos) b[7] = tei;
          e = (i == 9) ? pm : 8'h00;
          byte_valid <= 1'b1;
          byte_sop <= (i == 0);
          post_byte <= b ^ e;
          pre_byte <= b ^ e ^ ((i == 9) ? qm : 8'h00);
          rs_overload <= ovl && (i == 187);
          @(posedge sys_clk);
        end
        busy <= 1'b0;
        byte_valid <= 1'b0;
        byte_sop <= 1'b0;
        rs_overload <= 1'b0;
        // Released lines show the inverse so stale data never matches
        pre_byte <= ~pre_byte;
        post_byte <= ~post_byte;
      end
    end
  end
endmodule : tlem_src_model

// [tb.sv]
// Self-checking bench for the link error monitor
`timescale 1ns/1ps
module tb;
  import tlem_pkg::*;
  logic sys_clk, rst_b, in_sync, signal_ok, sec_tick, oos_mode;
  logic meas_clear, go, ovl, tei, busy, byte_valid, byte_sop;
  logic rs_overload, ber_unreliable, link_unavail, sync_lost, signal_lost;
  logic [7:0]        pre_byte, post_byte, pm, qm, res_secs;
  logic [LOG_AW-1:0] log_rd_idx;
  logic [BER_W-1:0]  ber_err_bits, ber_total_bits, post_err_count;
  logic [TIME_W-1:0] time_now, secs;
  logic [LOG_AW:0]   log_fill, n_log;
  tlem_entry_type    log_entry;
  int                failures, n_checks;

  tlem_monitor #(.RUN_N(4), .WIN_T(8), .WIN_M(8)) tlem_monitor_i (
    .sys_clk, .rst_b, .byte_valid, .byte_sop, .pre_byte, .post_byte,
    .rs_overload, .in_sync, .signal_ok, .sec_tick, .oos_mode, .meas_clear,
    .res_secs, .sus_pct(7'h64), .log_rd_idx, .ber_err_bits,
    .ber_total_bits, .ber_unreliable, .post_err_count, .link_unavail,
    .sync_lost, .signal_lost, .time_now, .log_fill, .log_entry);
  tlem_src_model tlem_src_model_i (
    .sys_clk, .go, .oos(oos_mode), .pm, .qm, .ovl, .tei, .busy,
    .byte_valid, .byte_sop, .pre_byte, .post_byte, .rs_overload);

  initial sys_clk = 1'b0;
  always #50 sys_clk = ~sys_clk;

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : stop_test

  task automatic pkt(input logic [7:0] p, q, input logic o, t);
    int n;
    pm <= p;
    qm <= q;
    ovl <= o;
    tei <= t;
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    n = 0;
    @(posedge sys_clk);
    while (busy !== 1'b0 && n < 400) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 400) failures++;
    repeat (2) @(posedge sys_clk);
  endtask : pkt

  task automatic tick;
    sec_tick <= 1'b1;
    @(posedge sys_clk);
    sec_tick <= 1'b0;
    secs++;
    repeat (3) @(posedge sys_clk);
  endtask : tick

  task automatic clr;
    meas_clear <= 1'b1;
    @(posedge sys_clk);
    meas_clear <= 1'b0;
    @(posedge sys_clk);
  endtask : clr

  task automatic t_oos;
    oos_mode <= 1'b1;
    repeat (2) @(posedge sys_clk);
    pkt(8'h07, 8'h00, 1'b0, 1'b0);
    chk(post_err_count, 48'h3);
    pkt(8'h81, 8'h00, 1'b0, 1'b0);
    chk(post_err_count, 48'h5);
    oos_mode <= 1'b0;
    $display("test oos done");
  endtask : t_oos

  task automatic t_insvc;
    clr();
    pkt(8'h00, 8'h03, 1'b0, 1'b0);
    chk(ber_err_bits, 48'h2);
    chk(ber_total_bits, 48'h5e0);
    chk(48'(ber_unreliable), 48'h1);
    pkt(8'h00, 8'h00, 1'b0, 1'b0);
    chk(ber_total_bits, 48'hbc0);
    chk(48'(ber_unreliable), 48'h0);
    chk(post_err_count, 48'h0);
    pkt(8'h00, 8'h01, 1'b1, 1'b0);
    chk(ber_err_bits | ber_total_bits, 48'h0);
    pkt(8'h00, 8'h00, 1'b0, 1'b1);
    res_secs <= 8'h02;
    tick();
    chk(48'(log_fill), 48'(n_log));
    tick();
    res_secs <= 8'h01;
    repeat (4) @(posedge sys_clk);
    n_log++;
    chk(48'(log_fill), 48'(n_log));
    chk(48'(log_entry.kind), 48'(EV_BLOCK));
    chk(48'(log_entry.arg), 48'h2);
    chk(48'(log_entry.pid), 48'h0a11);
    chk(48'(log_entry.total), 48'h2);
    chk(48'(log_entry.overload), 48'h1);
    $display("test in service done");
  endtask : t_insvc

  task automatic t_loss(input logic sig);
    logic [31:0] t0;
    t0 = secs;
    clr();
    if (sig) signal_ok <= 1'b0;
    else in_sync <= 1'b0;
    pkt(8'h00, 8'h01, 1'b0, 1'b0);
    chk(ber_total_bits, 48'h0);
    chk(48'(sig ? signal_lost : sync_lost), 48'h1);
    tick();
    tick();
    if (sig) signal_ok <= 1'b1;
    else in_sync <= 1'b1;
    repeat (6) @(posedge sys_clk);
    n_log++;
    chk(48'(log_fill), 48'(n_log));
    chk(48'(log_entry.kind), sig ? 48'(EV_SIGNAL) : 48'(EV_SYNC));
    chk(48'(log_entry.start), 48'(t0));
    chk(48'(log_entry.arg), 48'h2);
    if (sig) begin
      log_rd_idx <= 10'h1;
      repeat (3) @(posedge sys_clk);
      chk(48'(log_entry.kind), 48'(EV_SYNC));
      log_rd_idx <= 10'h0;
    end
    tick();
    tick();
    $display("test loss done");
  endtask : t_loss

  task automatic t_unavail;
    clr();
    pkt(8'h00, 8'h01, 1'b0, 1'b0);
    in_sync <= 1'b0;
    repeat (5) tick();
    chk(48'(link_unavail), 48'h1);
    in_sync <= 1'b1;
    @(posedge sys_clk);
    pkt(8'h00, 8'h01, 1'b0, 1'b0);
    chk(ber_err_bits, 48'h1);
    chk(ber_total_bits, 48'h5e0);
    repeat (9) tick();
    chk(48'(link_unavail), 48'h0);
    chk(48'(time_now), 48'(secs));
    $display("test unavailable done");
  endtask : t_unavail

  initial begin
    rst_b = 1'b0;
    in_sync = 1'b1;
    signal_ok = 1'b1;
    sec_tick = 1'b0;
    oos_mode = 1'b0;
    meas_clear = 1'b0;
    go = 1'b0;
    ovl = 1'b0;
    tei = 1'b0;
    pm = 8'h00;
    res_secs = 8'h01;
    qm = 8'h00;
    log_rd_idx = 10'h0;
    failures = 0;
    n_checks = 0;
    secs = 32'h0;
    n_log = 11'h0;
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    t_oos();
    t_insvc();
    t_loss(1'b0);
    t_loss(1'b1);
    t_unavail();
    stop_test();
  end

  // Whole run needs about 2000 cycles; fifteen times that means a hang
  initial begin
    repeat (30000) @(posedge sys_clk);
    failures++;
    stop_test();
  end
endmodule : tb
